// file: pwm_timer_defs.svh
// offsets, field positions, reset values and rates of the pwm timer
// assumes a 50 MHz bus clock and 32-bit axi4-lite register words
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH

`define CNT_W 16
`define ADDR_LO_W 5

`define CTRL_OFS 5'h00
`define ON_OFS 5'h04
`define HI_OFS 5'h08
`define LO_OFS 5'h0c
`define FRZ_SET_OFS 5'h10
`define FRZ_CLR_OFS 5'h14
`define STAT_OFS 5'h18
`define MASK_OFS 5'h1c

`define CTRL_W 7
`define CTRL_RUN 0
`define CTRL_SRC 1
`define CTRL_PRE 2
`define CTRL_CLKHI 3
`define CTRL_GATE 4
`define CTRL_DIV 6:5
`define CTRL_RST 7'h00
`define RELOAD_RST 16'h0000

`define EV_W 2
`define EV_TERM 0
`define EV_ONZERO 1

`define CLK_KHZ 17'd50000
`define FAST_KHZ 17'd16000
`define SLOW_KHZ 17'd32
`define PRESCALE_DIV 4'd10

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: pwm_timer_pkg.sv
// types shared by the pwm timer modules
// assumes pwm_timer_defs.svh is on the include path
`include "pwm_timer_defs.svh"
package pwm_timer_pkg;

	typedef enum logic {PH_HIGH, PH_LOW} phase_e;

	typedef struct packed {
		logic [16:0] acc;
		logic [3:0] pre_cnt;
		logic tick;
		logic half;
	} tick_s;

	typedef struct packed {
		logic [`EV_W-1:0] status;
		logic [`EV_W-1:0] mask;
		logic irq;
	} irq_s;

	typedef struct packed {
		logic [`CTRL_W-1:0] ctrl;
		logic frozen;
		logic [`CNT_W-1:0] on_reload;
		logic [`CNT_W-1:0] hi_reload;
		logic [`CNT_W-1:0] lo_reload;
		logic [`CNT_W-1:0] hi_shadow;
		logic [`CNT_W-1:0] lo_shadow;
		logic [`CNT_W-1:0] phase_cnt;
		logic [`CNT_W-1:0] on_cnt;
		phase_e phase_sel;
		logic pwm;
		logic irq_pulse;
		logic aw_full;
		logic aw_hi;
		logic [`ADDR_LO_W-1:0] aw_addr;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} timer_s;

endpackage

// file: tick_if.sv
// clock selection and tick enables between timer core and tick generator
// assumes both ends run on the one bus clock
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
	logic run;
	logic hold;
	logic src_sel;
	logic gate;
	logic prescale;
	logic [1:0] div;
	logic tick;
	logic on_tick;
	logic half;
	modport gen (input run, hold, src_sel, gate, prescale, div,
		output tick, on_tick, half);
	modport core (output run, hold, src_sel, gate, prescale, div,
		input tick, on_tick, half);
endinterface
`default_nettype wire

// file: clock_tick_gen.sv
// timer clock enables made from the bus clock by a fractional accumulator
// assumes a 50 MHz aclk; ticks jitter by one cycle, average rate is exact
`timescale 1ns/1ps
`default_nettype none
module clock_tick_gen import pwm_timer_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	tick_if.gen g
);
	tick_s s_reg;
	tick_s s_next;
	logic [16:0] add;
	logic [16:0] sum;

	// no tick at all while the fast source is picked but not gated on
	always_comb begin
		s_next = s_reg;
		add = g.src_sel ? (g.gate ? (`FAST_KHZ >> g.div) : 17'd0) : `SLOW_KHZ;
		sum = s_reg.acc + add;
		s_next.tick = 1'b0;
		if (!g.run) begin
			s_next = '0;
		end else if (!g.hold) begin
			if (sum >= `CLK_KHZ) begin
				s_next.acc = sum - `CLK_KHZ;
				s_next.tick = 1'b1;
			end else begin
				s_next.acc = sum;
			end
			if (s_reg.tick) begin
				s_next.half = !s_reg.half;
				if (s_reg.pre_cnt == `PRESCALE_DIV - 4'd1) begin
					s_next.pre_cnt = 4'd0;
				end else begin
					s_next.pre_cnt = s_reg.pre_cnt + 4'd1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign g.tick = s_reg.tick;
	assign g.half = s_reg.half;
	// divide-by-ten only on the interrupt counter enable
	assign g.on_tick = s_reg.tick &&
		(!g.prescale || s_reg.pre_cnt == `PRESCALE_DIV - 4'd1);

	tick_gap_a:
	assert property (@(posedge aclk) disable iff (!aresetn)
		g.tick |=> !g.tick)
		else $error("timer tick on two adjacent cycles");

endmodule // clock_tick_gen
`default_nettype wire

// file: irq_status.sv
// sticky event status, mask and one level interrupt line
// assumes clear and mask writes arrive as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module irq_status import pwm_timer_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`EV_W-1:0] set_ev,
	input wire logic clr_we,
	input wire logic [`EV_W-1:0] clr_bits,
	input wire logic mask_we,
	input wire logic [`EV_W-1:0] mask_bits,
	output logic [`EV_W-1:0] status,
	output logic [`EV_W-1:0] mask,
	output logic irq
);
	irq_s s_reg;
	irq_s s_next;

	// set beats a clear landing in the same cycle
	always_comb begin
		s_next = s_reg;
		for (int i = 0; i < `EV_W; i++) begin
			s_next.status[i] = set_ev[i] ||
				(s_reg.status[i] && !(clr_we && clr_bits[i]));
		end
		if (mask_we) begin
			s_next.mask = mask_bits;
		end
		s_next.irq = |(s_next.status & s_next.mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign status = s_reg.status;
	assign mask = s_reg.mask;
	assign irq = s_reg.irq;

	set_wins_a:
	assert property (@(posedge aclk) disable iff (!aresetn)
		set_ev[`EV_TERM] |=> status[`EV_TERM])
		else $error("terminal event lost against a clear");

endmodule // irq_status
`default_nettype wire

// file: pwm_timer.sv
// What this block does
// - reset clears both counters and the three reload registers to zero
// - five timer clocks; 32 kHz is the default source selection
// - prescale enable divides only the interrupt counter clock by ten
// - run loads phase and interrupt counters, then they count down
// - phase counter zero toggles phase select, reloads high or low shadow
// - true output high in high phase, low otherwise; inverse is complement
// - clocked-high mode outputs half-rate square wave during high phase
// - interrupt counter waits at zero until low phase also ends
// - joint end raises interrupt, reloads counters and both shadows
// - reload writes always accepted; shadows update only at joint end
// - start state is the joint end, so starting interrupts at once
// - disabled timer zeroes counters, shadows, pwm and pulse; reloads, freeze, status and mask keep theirs
// - period reload address reads interrupt count, phase ones phase count
// - freeze set and clear registers stop and resume all counting
// - pwm period is (M+1)+(N+1) ticks, high time M+1 ticks
// - interrupt period ends at the first low phase end after ON interrupt clock ticks, a whole number of pwm periods
//
// dual phase pwm timer with an axi4-lite register slave
// assumes aclk at 50 MHz, synchronous active-low reset, one access at a time
`timescale 1ns/1ps
`default_nettype none
module pwm_timer import pwm_timer_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic true_pwm_output,
	output logic inverted_pwm_output,
	output logic timer_interrupt,
	output logic irq
);
	timer_s s_reg;
	timer_s s_next;
	tick_if tk();
	logic run;
	logic wr_go;
	logic joint;
	logic [`EV_W-1:0] ev;
	logic stat_we;
	logic mask_we;
	logic [`EV_W-1:0] status;
	logic [`EV_W-1:0] mask;
	logic [`ADDR_LO_W-1:0] ra;

	function automatic logic [`CNT_W-1:0] merge16(
		input logic [`CNT_W-1:0] old,
		input logic [31:0] d,
		input logic [3:0] be
	);
		logic [`CNT_W-1:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = d[7:0];
		end
		if (be[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	assign run = s_reg.ctrl[`CTRL_RUN];
	assign tk.run = run;
	assign tk.hold = s_reg.frozen;
	assign tk.src_sel = s_reg.ctrl[`CTRL_SRC];
	assign tk.gate = s_reg.ctrl[`CTRL_GATE];
	assign tk.div = s_reg.ctrl[`CTRL_DIV];
	assign tk.prescale = s_reg.ctrl[`CTRL_PRE];

	clock_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.g(tk.gen)
	);

	// channel readies: one write and one read in flight at most
	assign awready = !s_reg.aw_full && !s_reg.bvalid;
	assign wready = !s_reg.w_full && !s_reg.bvalid;
	assign arready = !s_reg.rvalid;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign rvalid = s_reg.rvalid;
	assign rresp = s_reg.rresp;
	assign rdata = s_reg.rdata;
	assign wr_go = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
	assign ra = araddr[`ADDR_LO_W-1:0];

	assign stat_we = wr_go && !s_reg.aw_hi &&
		s_reg.aw_addr == `STAT_OFS && s_reg.wstrb[0];
	assign mask_we = wr_go && !s_reg.aw_hi &&
		s_reg.aw_addr == `MASK_OFS && s_reg.wstrb[0];

	always_comb begin
		s_next = s_reg;
		s_next.irq_pulse = 1'b0;
		joint = 1'b0;
		ev = '0;

		// address and data may come in either order
		if (awvalid && awready) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = awaddr[`ADDR_LO_W-1:0];
			s_next.aw_hi = |awaddr[ADDR_W-1:`ADDR_LO_W];
		end
		if (wvalid && wready) begin
			s_next.w_full = 1'b1;
			s_next.wdata = wdata;
			s_next.wstrb = wstrb;
		end
		if (s_reg.bvalid && bready) begin
			s_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `RESP_OKAY;
			if (s_reg.aw_hi) begin
				s_next.bresp = `RESP_SLVERR;
			end else begin
				unique case (s_reg.aw_addr)
					`CTRL_OFS: begin
						if (s_reg.wstrb[0]) begin
							s_next.ctrl = s_reg.wdata[`CTRL_W-1:0];
						end
					end
					// reload writes land at any time, shadows decide use
					`ON_OFS: begin
						s_next.on_reload = merge16(s_reg.on_reload,
							s_reg.wdata, s_reg.wstrb);
					end
					`HI_OFS: begin
						s_next.hi_reload = merge16(s_reg.hi_reload,
							s_reg.wdata, s_reg.wstrb);
					end
					`LO_OFS: begin
						s_next.lo_reload = merge16(s_reg.lo_reload,
							s_reg.wdata, s_reg.wstrb);
					end
					`FRZ_SET_OFS: begin
						if (s_reg.wstrb[0] && s_reg.wdata[0]) begin
							s_next.frozen = 1'b1;
						end
					end
					`FRZ_CLR_OFS: begin
						if (s_reg.wstrb[0] && s_reg.wdata[0]) begin
							s_next.frozen = 1'b0;
						end
					end
					`STAT_OFS, `MASK_OFS: begin
					end
					default: begin
						s_next.bresp = `RESP_SLVERR;
					end
				endcase
			end
		end

		if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `RESP_OKAY;
			s_next.rdata = '0;
			if (|araddr[ADDR_W-1:`ADDR_LO_W]) begin
				s_next.rresp = `RESP_SLVERR;
			end else begin
				unique case (ra)
					`CTRL_OFS: begin
						s_next.rdata[`CTRL_W-1:0] = s_reg.ctrl;
					end
					// live counters, not the written reload values
					`ON_OFS: begin
						s_next.rdata[`CNT_W-1:0] = s_reg.on_cnt;
					end
					`HI_OFS, `LO_OFS: begin
						s_next.rdata[`CNT_W-1:0] = s_reg.phase_cnt;
					end
					`FRZ_SET_OFS, `FRZ_CLR_OFS: begin
						s_next.rdata[0] = s_reg.frozen;
					end
					`STAT_OFS: begin
						s_next.rdata[`EV_W-1:0] = status;
					end
					`MASK_OFS: begin
						s_next.rdata[`EV_W-1:0] = mask;
					end
					default: begin
						s_next.rresp = `RESP_SLVERR;
					end
				endcase
			end
		end

		// timer core
		if (!run) begin
			s_next.phase_cnt = '0;
			s_next.on_cnt = '0;
			s_next.hi_shadow = '0;
			s_next.lo_shadow = '0;
			s_next.phase_sel = PH_LOW;
		end else if (!s_reg.frozen) begin
			if (tk.on_tick && s_reg.on_cnt != '0) begin
				s_next.on_cnt = s_reg.on_cnt - 16'd1;
				ev[`EV_ONZERO] = s_reg.on_cnt == 16'd1;
			end
			if (tk.tick) begin
				if (s_reg.phase_cnt != '0) begin
					s_next.phase_cnt = s_reg.phase_cnt - 16'd1;
				end else if (s_reg.phase_sel == PH_HIGH) begin
					s_next.phase_cnt = s_reg.lo_shadow;
					s_next.phase_sel = PH_LOW;
				end else if (s_reg.on_cnt != '0) begin
					// interrupt counter still busy: another pwm period
					s_next.phase_cnt = s_reg.hi_shadow;
					s_next.phase_sel = PH_HIGH;
				end else begin
					// low phase done and interrupt counter parked at zero
					joint = 1'b1;
					s_next.on_cnt = s_reg.on_reload;
					s_next.phase_cnt = s_reg.hi_reload;
					s_next.hi_shadow = s_reg.hi_reload;
					s_next.lo_shadow = s_reg.lo_reload;
					s_next.phase_sel = PH_HIGH;
					s_next.irq_pulse = 1'b1;
					ev[`EV_TERM] = 1'b1;
				end
			end
		end
		// taken from the next phase select, so it changes in the same cycle as the phase
		s_next.pwm = run && s_next.phase_sel == PH_HIGH &&
			(!s_reg.ctrl[`CTRL_CLKHI] || tk.half);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.phase_sel <= PH_LOW;
		end else begin
			s_reg <= s_next;
		end
	end

	irq_status u_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_ev(ev),
		.clr_we(stat_we),
		.clr_bits(s_reg.wdata[`EV_W-1:0]),
		.mask_we(mask_we),
		.mask_bits(s_reg.wdata[`EV_W-1:0]),
		.status(status),
		.mask(mask),
		.irq(irq)
	);

	assign true_pwm_output = s_reg.pwm;
	assign inverted_pwm_output = !s_reg.pwm;
	assign timer_interrupt = s_reg.irq_pulse;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	rst_zero_a:
	assert property ($past(!aresetn) |-> s_reg.phase_cnt == '0 &&
		s_reg.on_cnt == '0 && s_reg.hi_reload == '0 &&
		s_reg.lo_reload == '0 && s_reg.on_reload == '0)
		else $error("counters or reloads not zero after reset");

	disabled_hold_a:
	assert property (!run |=> s_reg.phase_cnt == '0 && s_reg.on_cnt == '0
		&& !timer_interrupt && !true_pwm_output)
		else $error("disabled timer left its reset state");

	low_phase_a:
	assert property (s_reg.phase_sel == PH_LOW ##1 s_reg.phase_sel == PH_LOW
		|-> !true_pwm_output && inverted_pwm_output)
		else $error("pwm high during low phase");

	freeze_hold_a:
	assert property (run && s_reg.frozen |=> $stable(s_reg.phase_cnt) &&
		$stable(s_reg.on_cnt) && !timer_interrupt)
		else $error("frozen timer moved");

	joint_load_a:
	assert property (timer_interrupt |-> s_reg.phase_sel == PH_HIGH &&
		s_reg.phase_cnt == s_reg.hi_shadow &&
		s_reg.on_cnt == $past(s_reg.on_reload))
		else $error("joint end reload wrong");

	one_pulse_a:
	assert property (timer_interrupt |=> !timer_interrupt [*2])
		else $error("interrupt pulse longer than one cycle");

	on_park_a:
	assert property (s_reg.on_cnt == '0 && !joint |=> s_reg.on_cnt == '0)
		else $error("interrupt counter left zero early");

	shadow_hold_a:
	assert property (run && !joint |=> $stable(s_reg.hi_shadow) &&
		$stable(s_reg.lo_shadow))
		else $error("shadow changed outside the joint end");

	on_rate_a:
	assert property (run && !joint && !tk.on_tick |=> $stable(s_reg.on_cnt))
		else $error("interrupt counter moved without its tick");

	start_irq_a:
	assert property (run && !s_reg.frozen && tk.tick &&
		s_reg.phase_sel == PH_LOW && s_reg.phase_cnt == '0 &&
		s_reg.on_cnt == '0 |=> timer_interrupt)
		else $error("no interrupt at the joint end");

	period_a:
	assert property (run && !s_reg.frozen && tk.tick &&
		s_reg.phase_sel == PH_HIGH && s_reg.phase_cnt == '0 |=>
		s_reg.phase_sel == PH_LOW && s_reg.phase_cnt == s_reg.lo_shadow)
		else $error("low phase not loaded from its shadow");

	irq_cov_c: cover property (timer_interrupt);
	pwm_cov_c: cover property ($rose(true_pwm_output));
	freeze_cov_c: cover property (run && s_reg.frozen && tk.tick);
	clkhi_cov_c: cover property (s_reg.ctrl[`CTRL_CLKHI] &&
		s_reg.phase_sel == PH_HIGH && $fell(true_pwm_output));

endmodule // pwm_timer
`default_nettype wire

// file: dual_phase_pwm_timer_bench.sv
// self-checking bench for the dual phase pwm timer top, pwm_timer
// assumes the timer sources and pwm_timer_defs.svh are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_defs.svh"
`define CHK(g, e, m) begin \
	checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("mismatch at %0t: %s", $time, m); \
	end \
end
module dual_phase_pwm_timer_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b1;
	logic [11:0] araddr = 12'h000;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b1;
	logic pwm, pwm_n, tint, irq;
	int fails = 0;
	int checks = 0;

	always #10 aclk = ~aclk;

	pwm_timer #(.ADDR_W(12)) uut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.true_pwm_output(pwm), .inverted_pwm_output(pwm_n),
		.timer_interrupt(tint), .irq(irq));

	function automatic logic [11:0] ad(input logic [4:0] o);
		return {7'h00, o};
	endfunction

	task wrap_up;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ready lines stay high, so no answer can be missed
	task automatic wrr(input logic [11:0] a, input logic [31:0] d,
			output logic [1:0] r);
		logic ad_ok, wd_ok;
		ad_ok = 1'b0;
		wd_ok = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (!(ad_ok && wd_ok)) begin
			@(posedge aclk);
			if (awready && !ad_ok) begin
				ad_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !wd_ok) begin
				wd_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	task automatic wr(input logic [4:0] o, input logic [31:0] d);
		logic [1:0] r;
		wrr(ad(o), d, r);
		`CHK(r, `RESP_OKAY, "write response")
	endtask

	task automatic rd_chk(input logic [4:0] o, input logic [31:0] e,
			input string m);
		logic [31:0] d;
		logic [1:0] r;
		rd(ad(o), d, r);
		`CHK(d, e, m)
	endtask

	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (tint !== 1'b1);
	endtask

	// pulse to pulse: cycles, high cycles, rising edges of the output
	task automatic span(output int hi, output int per, output int ri);
		logic prev;
		int n;
		hi = 0;
		per = 0;
		ri = 0;
		prev = 1'b1;
		wait_pulse(n);
		do begin
			@(posedge aclk);
			per++;
			if (per == 1)
				`CHK(tint, 1'b0, "pulse longer than one cycle")
			`CHK(pwm_n, ~pwm, "outputs not complementary")
			if (pwm === 1'b1)
				hi++;
			if (pwm === 1'b1 && prev === 1'b0)
				ri++;
			prev = pwm;
		end while (tint !== 1'b1);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rd_chk(`CTRL_OFS, 32'h0, "ctrl reset, slow source");
		rd_chk(`ON_OFS, 32'h0, "interrupt counter reset");
		rd_chk(`HI_OFS, 32'h0, "phase counter reset");
		rd_chk(`STAT_OFS, 32'h0, "status reset");
		rd_chk(`MASK_OFS, 32'h0, "mask reset");
		rd_chk(`FRZ_SET_OFS, 32'h0, "freeze reset");
		rd(12'h020, d, r);
		`CHK(r, `RESP_SLVERR, "unmapped read")
		wrr(12'h024, 32'hffff_ffff, r);
		`CHK(r, `RESP_SLVERR, "unmapped write")
	endtask

	// 2 MHz fast source: one tick every 25 bus cycles exactly
	task automatic t_period;
		int hi, per, ri, n;
		wr(`HI_OFS, 32'h1);
		wr(`LO_OFS, 32'h2);
		wr(`ON_OFS, 32'h0);
		wr(`CTRL_OFS, 32'h73);
		wait_pulse(n);
		`CHK(n <= 30, 1'b1, "no interrupt at start")
		span(hi, per, ri);
		`CHK(hi, 50, "high time")
		`CHK(per, 125, "pwm period")
		wr(`HI_OFS, 32'h3);
		span(hi, per, ri);
		`CHK(hi, 100, "new high value not taken")
		`CHK(per, 175, "period after reload")
	endtask

	// joint end only at a low phase end, so periods are whole pwm periods
	task automatic t_irq_period;
		int hi, per, ri;
		wr(`HI_OFS, 32'h0);
		wr(`LO_OFS, 32'h0);
		wr(`ON_OFS, 32'h4);
		span(hi, per, ri);
		span(hi, per, ri);
		`CHK(per >= 125 && per <= 175, 1'b1, "interrupt period")
		`CHK(per % 50, 0, "interrupt off a low end")
		// free-running prescaler: four decrements land 31..40 ticks on
		wr(`CTRL_OFS, 32'h77);
		span(hi, per, ri);
		span(hi, per, ri);
		`CHK(per >= 800 && per <= 1050, 1'b1, "prescaled period")
		`CHK(per % 50, 0, "prescale touched phase")
	endtask

	task automatic t_clocked;
		int hi, per, ri;
		wr(`ON_OFS, 32'h0);
		wr(`HI_OFS, 32'h3);
		wr(`CTRL_OFS, 32'h7b);
		span(hi, per, ri);
		span(hi, per, ri);
		`CHK(ri >= 2, 1'b1, "no clock in high phase")
		`CHK(per, 125, "clocked period")
	endtask

	task automatic t_freeze;
		logic [31:0] v1, v2, v3;
		logic [1:0] r;
		logic p1;
		int hi, per, ri, seen;
		seen = 0;
		wr(`FRZ_SET_OFS, 32'h1);
		rd_chk(`FRZ_SET_OFS, 32'h1, "freeze bit");
		rd(ad(`HI_OFS), v1, r);
		p1 = pwm;
		repeat (200) begin
			@(posedge aclk);
			if (tint === 1'b1)
				seen++;
		end
		rd(ad(`HI_OFS), v2, r);
		rd(ad(`LO_OFS), v3, r);
		`CHK(v2, v1, "counter moved while frozen")
		`CHK(v3, v2, "phase reads differ")
		`CHK(pwm, p1, "output moved while frozen")
		`CHK(seen, 0, "interrupt while frozen")
		wr(`FRZ_CLR_OFS, 32'h1);
		rd_chk(`FRZ_CLR_OFS, 32'h0, "freeze not released");
		span(hi, per, ri);
		`CHK(per, 125, "period after freeze")
	endtask

	task automatic t_stop;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		rd(ad(`STAT_OFS), d, r);
		`CHK(d[0], 1'b1, "joint end status")
		`CHK(irq, 1'b0, "masked irq")
		wr(`MASK_OFS, 32'h1);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b1, "unmasked irq")
		wr(`CTRL_OFS, 32'h0);
		rd_chk(`ON_OFS, 32'h0, "interrupt counter kept");
		rd_chk(`HI_OFS, 32'h0, "phase counter kept");
		`CHK(pwm, 1'b0, "output not reset")
		`CHK(pwm_n, 1'b1, "inverse not reset")
		wr(`STAT_OFS, 32'h3);
		rd_chk(`STAT_OFS, 32'h0, "status not cleared");
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b0, "irq after clear")
		// stopped timer waits at the joint end, so restart interrupts at once
		wr(`CTRL_OFS, 32'h73);
		wait_pulse(n);
		`CHK(n <= 30, 1'b1, "no interrupt at restart")
	endtask

	// 16, 8 and 4 MHz fast rates and the slow source; reloads chosen so each period is whole cycles
	task automatic t_rates;
		int hi, per, ri, seen;
		for (int d = 0; d < 3; d++) begin
			wr(`CTRL_OFS, 32'h0);
			wr(`HI_OFS, (32'h4 >> d) - 32'h1);
			wr(`LO_OFS, (32'h4 >> d) - 32'h1);
			wr(`CTRL_OFS, 32'h13 | (d << 5));
			span(hi, per, ri);
			`CHK(per, 25, "fast rate period")
		end
		// fast source picked but gate off: no ticks at all
		wr(`CTRL_OFS, 32'h03);
		repeat (3) @(posedge aclk);
		seen = 0;
		repeat (60) begin
			@(posedge aclk);
			if (tint === 1'b1)
				seen++;
		end
		`CHK(seen, 0, "ungated fast source ticked")
		wr(`CTRL_OFS, 32'h01);
		span(hi, per, ri);
		`CHK(per, 3125, "slow source period")
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_period();
		t_irq_period();
		t_clocked();
		t_freeze();
		t_stop();
		t_rates();
		wrap_up();
	end

	// whole run is under 15000 cycles
	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		$display("mismatch at %0t: watchdog", $time);
		wrap_up();
	end
endmodule // dual_phase_pwm_timer_bench
`default_nettype wire
